// ---- pfhd_pkg.sv ----
// constants, pin bundles and lane-select bundles for the paged flash host decode block
// assumes a 10 MHz sys_clk; bus pins are asynchronous to it and synchronised first, but raw supply_ok and bus_reset also clear the supply flop
package pfhd_pkg;

  // ************************************************************
  // widths and field positions
  // ************************************************************
  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int PAGE_W     = 8;
  localparam int OFFS_W     = 16;
  localparam int PAIRS      = 8;
  localparam int NIBBLE_W   = 4;
  localparam int WIN_LO     = 16;
  localparam int WIN_HI     = 20;
  localparam int SEL_W      = 3;
  localparam int CS_SEL_LSB = 2;
  localparam int SUPPLY_BIT = 0;
  localparam int LANE_LO    = 0;
  localparam int LANE_HI    = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PAGE_W-1:0] PAGE_RESET  = 8'h00;
  localparam logic [PAIRS-1:0]  CS_IDLE     = 8'hFF;
  localparam logic [1:0]        LANES_OFF   = 2'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 24'h000000;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PFHD_IDLE   = 2'b00,
    PFHD_MEM_RD = 2'b01,
    PFHD_MEM_WR = 2'b10,
    PFHD_IO_RD  = 2'b11
  } pfhd_cycle_t;

  typedef struct packed {
    logic [ADDR_W-1:0] sa;
    logic [DATA_W-1:0] sd;
    logic [DATA_W-1:0] fd;
    logic [PAGE_W-1:0] base_sw;
    logic              aen;
    logic              memr_n;
    logic              memw_n;
    logic              ior_n;
    logic              iow_n;
    logic              sbhe_n;
    logic              page_port_sel_n;
    logic              base_port_sel_n;
    logic              prog_supply_port_strobe_n;
    logic              wide_bus_present_n;
    logic              bus_reset;
    logic              supply_ok;
    logic              wide_window;
    logic              eight_pair;
    logic              uv_gates_decode;
  } pfhd_pins_t;

  // strobes idle high, supply treated as bad until seen good
  localparam pfhd_pins_t PINS_IDLE = '{
    sa: 24'h000000, sd: 16'h0000, fd: 16'h0000, base_sw: 8'h00,
    aen: 1'b1, memr_n: 1'b1, memw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1,
    page_port_sel_n: 1'b1, base_port_sel_n: 1'b1, prog_supply_port_strobe_n: 1'b1,
    wide_bus_present_n: 1'b1, bus_reset: 1'b1, supply_ok: 1'b0,
    wide_window: 1'b0, eight_pair: 1'b0, uv_gates_decode: 1'b0};

  typedef struct packed {
    logic [PAIRS-1:0] lo_n;
    logic [PAIRS-1:0] hi_n;
    logic             lo_lane;
    logic             hi_lane;
    logic             swap;
  } pfhd_sel_t;

endpackage : pfhd_pkg

// ---- pfhd_sync.sv ----
// two-flip-flop synchroniser for a bundle of asynchronous pins
// assumes each bit is independent; multi-bit values are sampled while stable on the bus
`timescale 1ns/100ps
`default_nettype none
module pfhd_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  input  wire logic [W-1:0]  d,
  output var  logic [W-1:0]  q
);

  // ************************************************************
  // per-bit double flop
  // ************************************************************
  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        meta[i] <= INIT[i];
        q[i]    <= INIT[i];
      end else if (clk_en) begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule : pfhd_sync
`default_nettype wire

// ---- pfhd_cs_decode.sv ----
// chip-select and byte-lane decode for the flash pair array
// assumes all inputs are synchronous and settled; purely combinational
`timescale 1ns/100ps
`default_nettype none
module pfhd_cs_decode
  import pfhd_pkg::*;
(
  input  wire logic             en,
  input  wire logic             eight_pair,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             a0,
  input  wire logic             wide,
  input  wire logic             sbhe_n,
  output pfhd_pkg::pfhd_sel_t   lanes
);

  // ************************************************************
  // card enables from bus width and byte enables
  // ************************************************************
  wire             word_acc = wide && !sbhe_n && !a0;
  wire             odd_hi   = wide && !sbhe_n && a0;
  wire             ce1      = en && !odd_hi;               // RULE2
  wire             ce2      = en && (word_acc || odd_hi);  // RULE2
  wire [SEL_W-1:0] idx      = eight_pair ? sel : {1'b0, sel[1:0]}; // RULE1 RULE4

  assign lanes.lo_lane = ce1 && (ce2 || !a0);             // RULE2
  assign lanes.hi_lane = ce2 || (ce1 && a0);               // RULE2
  assign lanes.swap    = ce1 && !ce2 && a0;                // RULE3

  // ************************************************************
  // one select pair per flash pair
  // ************************************************************
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    wire pair_hit = (idx == SEL_W'(p));
    assign lanes.lo_n[p] = !(pair_hit && lanes.lo_lane);  // RULE1
    assign lanes.hi_n[p] = !(pair_hit && lanes.hi_lane);  // RULE1
  end

endmodule : pfhd_cs_decode
`default_nettype wire

// ---- pfhd_top.sv ----
// paged flash board decode: window compare, page latch, byte-lane steering, supply enable
// assumes bus pins are asynchronous to sys_clk; bus cycles last several sys_clk periods
//
// Overview of operation
// RULE1: two page bits pick one of four pairs
// RULE2: card enables and A0 pick byte lanes
// RULE3: eight-bit host gets high byte on low lanes
// RULE4: optional three-bit decode over eight pairs
// RULE5: low sixteen address bits pass, page supplies rest
// RULE6: four address bits compared with base switches
// RULE7: decode only on window hit with aen low
// RULE8: optional wider compare, base readable on data
// RULE9: supply enable off at reset or low supply
// RULE10: supply flop captures at write strobe rise
// RULE11: host writes one on, zero off
// RULE12: undervoltage or bus reset clears supply flop asynchronously
// RULE13: optional undervoltage gate on chip selects
// RULE14: host waits for supply settling before programming
// RULE15: page register clears to zero at reset
// RULE16: page port read returns latched page
// RULE17: no hit or aen high keeps selects off
`timescale 1ns/100ps
`default_nettype none
module pfhd_top
  import pfhd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  input  wire logic [ADDR_W-1:0]    sa,
  input  wire logic [DATA_W-1:0]    sd_in,
  output var  logic [DATA_W-1:0]    sd_out,
  output var  logic [1:0]           sd_oe_n,
  input  wire logic                 aen,
  input  wire logic                 memr_n,
  input  wire logic                 memw_n,
  input  wire logic                 ior_n,
  input  wire logic                 iow_n,
  input  wire logic                 sbhe_n,
  input  wire logic                 page_port_sel_n,
  input  wire logic                 base_port_sel_n,
  input  wire logic                 prog_supply_port_strobe_n,
  input  wire logic                 wide_bus_present_n,
  input  wire logic                 bus_reset,
  input  wire logic                 supply_ok,
  input  wire logic [PAGE_W-1:0]    base_sw,
  input  wire logic                 wide_window,
  input  wire logic                 eight_pair,
  input  wire logic                 uv_gates_decode,
  input  wire logic [DATA_W-1:0]    fd_in,
  output var  logic [DATA_W-1:0]    fd_out,
  output var  logic [1:0]           fd_oe_n,
  output var  logic [ADDR_W-1:0]    flash_addr,
  output var  logic [PAIRS-1:0]     flash_ce_lo_n,
  output var  logic [PAIRS-1:0]     flash_ce_hi_n,
  output var  logic                 flash_oe_n,
  output var  logic                 flash_we_n,
  output var  logic                 prog_supply_en,
  output var  logic [PAGE_W-1:0]    page_number
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  pfhd_pins_t pins_raw;
  pfhd_pins_t s;

  assign pins_raw = '{
    sa: sa, sd: sd_in, fd: fd_in, base_sw: base_sw,
    aen: aen, memr_n: memr_n, memw_n: memw_n, ior_n: ior_n, iow_n: iow_n, sbhe_n: sbhe_n,
    page_port_sel_n: page_port_sel_n, base_port_sel_n: base_port_sel_n,
    prog_supply_port_strobe_n: prog_supply_port_strobe_n,
    wide_bus_present_n: wide_bus_present_n, bus_reset: bus_reset, supply_ok: supply_ok,
    wide_window: wide_window, eight_pair: eight_pair, uv_gates_decode: uv_gates_decode};

  pfhd_sync #(
    .W    ($bits(pfhd_pins_t)),
    .INIT (PINS_IDLE)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .d       (pins_raw),
    .q       (s)
  );

  // ************************************************************
  // write strobe history
  // ************************************************************
  // port selects and data are taken from the cycle before the strobe rises,
  // because the host may drop them together with the strobe
  logic              iow_q;
  logic              supply_sel_q;
  logic              page_sel_q;
  logic [DATA_W-1:0] data_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      iow_q        <= 1'b1;
      supply_sel_q <= 1'b1;
      page_sel_q   <= 1'b1;
      data_q       <= DATA_ZERO;
    end else if (clk_en) begin
      iow_q        <= s.iow_n;
      supply_sel_q <= s.prog_supply_port_strobe_n;
      page_sel_q   <= s.page_port_sel_n;
      data_q       <= s.sd;
    end
  end

  wire iow_rise      = !iow_q && s.iow_n;
  wire supply_write  = iow_rise && !supply_sel_q;             // RULE10
  wire page_write    = iow_rise && !page_sel_q;
  wire state_clear   = s.bus_reset || !s.supply_ok;

  // ************************************************************
  // programming supply enable
  // ************************************************************
  // cleared straight from the pins so the supply drops without waiting for sys_clk
  wire supply_clear_n = supply_ok && !bus_reset;              // RULE12

  always_ff @(posedge sys_clk or negedge supply_clear_n) begin
    if (!supply_clear_n) begin
      prog_supply_en <= 1'b0;                                  // RULE12
    end else if (!reset_n) begin
      prog_supply_en <= 1'b0;                                  // RULE9
    end else if (clk_en) begin
      if (state_clear) begin
        prog_supply_en <= 1'b0;                                // RULE9
      end else if (supply_write) begin
        prog_supply_en <= data_q[SUPPLY_BIT];                  // RULE10 RULE11
      end
    end
  end

  // ************************************************************
  // page register
  // ************************************************************
  logic [PAGE_W-1:0] next_page_number;

  always_comb begin
    next_page_number = page_number;
    if (state_clear) begin
      next_page_number = PAGE_RESET;                           // RULE15
    end else if (page_write) begin
      next_page_number = data_q[PAGE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      page_number <= PAGE_RESET;                               // RULE15
    end else if (clk_en) begin
      page_number <= next_page_number;
    end
  end

  // ************************************************************
  // window compare and memory decode enable
  // ************************************************************
  wire win_lo_match = (s.sa[WIN_LO +: NIBBLE_W] == s.base_sw[0 +: NIBBLE_W]);         // RULE6
  wire win_hi_match = (s.sa[WIN_HI +: NIBBLE_W] == s.base_sw[NIBBLE_W +: NIBBLE_W]);  // RULE8
  wire window_hit   = win_lo_match && (!s.wide_window || win_hi_match);              // RULE6 RULE8
  wire supply_gate  = !s.uv_gates_decode || s.supply_ok;                              // RULE13
  wire mem_rd       = !s.memr_n;
  wire mem_wr       = !s.memw_n && s.memr_n;
  wire mem_en       = window_hit && !s.aen && (mem_rd || mem_wr) && supply_gate;     // RULE7 RULE17
  wire wide_bus     = !s.wide_bus_present_n;
  wire io_rd        = !s.ior_n && !s.aen;
  wire page_rd      = io_rd && !s.page_port_sel_n;
  wire base_rd      = io_rd && !s.base_port_sel_n && s.page_port_sel_n;

  pfhd_sel_t lanes;

  pfhd_cs_decode u_decode (
    .en         (mem_en),
    .eight_pair (s.eight_pair),
    .sel        (page_number[CS_SEL_LSB +: SEL_W]),
    .a0         (s.sa[0]),
    .wide       (wide_bus),
    .sbhe_n     (s.sbhe_n),
    .lanes      (lanes)
  );

  // ************************************************************
  // cycle state
  // ************************************************************
  pfhd_cycle_t next_cycle;

  assign next_cycle = mem_en && mem_rd      ? PFHD_MEM_RD :
                      mem_en                ? PFHD_MEM_WR :
                      (page_rd || base_rd)  ? PFHD_IO_RD  : PFHD_IDLE;

  // ************************************************************
  // output next values
  // ************************************************************
  logic [DATA_W-1:0] next_sd_out;
  logic [1:0]        next_sd_oe_n;
  logic [DATA_W-1:0] next_fd_out;
  logic [1:0]        next_fd_oe_n;
  logic              next_flash_oe_n;
  logic              next_flash_we_n;

  always_comb begin
    next_sd_out     = DATA_ZERO;
    next_sd_oe_n    = LANES_OFF;
    next_fd_out     = DATA_ZERO;
    next_fd_oe_n    = LANES_OFF;
    next_flash_oe_n = 1'b1;
    next_flash_we_n = 1'b1;
    case (next_cycle)
      PFHD_MEM_RD: begin
        next_flash_oe_n = 1'b0;
        if (lanes.swap) begin
          next_sd_out[0 +: BYTE_W] = s.fd[BYTE_W +: BYTE_W];   // RULE3
          next_sd_oe_n[LANE_LO]    = 1'b0;
        end else begin
          next_sd_out              = s.fd;
          next_sd_oe_n[LANE_LO]    = !lanes.lo_lane;
          next_sd_oe_n[LANE_HI]    = !lanes.hi_lane;
        end
      end
      PFHD_MEM_WR: begin
        next_flash_we_n = 1'b0;
        if (lanes.swap) begin
          next_fd_out[BYTE_W +: BYTE_W] = s.sd[0 +: BYTE_W];   // RULE3
          next_fd_oe_n[LANE_HI]         = 1'b0;
        end else begin
          next_fd_out                   = s.sd;
          next_fd_oe_n[LANE_LO]         = !lanes.lo_lane;
          next_fd_oe_n[LANE_HI]         = !lanes.hi_lane;
        end
      end
      PFHD_IO_RD: begin
        next_sd_oe_n[LANE_LO] = 1'b0;
        if (page_rd) begin
          next_sd_out[0 +: PAGE_W] = page_number;              // RULE16
        end else begin
          next_sd_out[0 +: PAGE_W] = s.base_sw;                // RULE8
        end
      end
      default: begin
        next_sd_oe_n = LANES_OFF;                              // RULE17
      end
    endcase
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sd_out        <= DATA_ZERO;
      sd_oe_n       <= LANES_OFF;
      fd_out        <= DATA_ZERO;
      fd_oe_n       <= LANES_OFF;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_ce_lo_n <= CS_IDLE;
      flash_ce_hi_n <= CS_IDLE;
      flash_addr    <= ADDR_ZERO;
    end else if (clk_en) begin
      sd_out        <= next_sd_out;
      sd_oe_n       <= next_sd_oe_n;
      fd_out        <= next_fd_out;
      fd_oe_n       <= next_fd_oe_n;
      flash_oe_n    <= next_flash_oe_n;
      flash_we_n    <= next_flash_we_n;
      flash_ce_lo_n <= lanes.lo_n;                             // RULE1 RULE17
      flash_ce_hi_n <= lanes.hi_n;                             // RULE1 RULE17
      flash_addr    <= {next_page_number, s.sa[0 +: OFFS_W]};  // RULE5
    end
  end

endmodule : pfhd_top
`default_nettype wire

// ---- pfhd_sva.sv ----
// assertions on the ports of the paged flash decode top, bound in below
// assumes clk_en high outside one short freeze; each pin reaches the outputs three edges later, except raw supply_ok and bus_reset clear prog_supply_en at once
`timescale 1ns/100ps
`default_nettype none
module pfhd_sva
  import pfhd_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire logic [ADDR_W-1:0] sa,
  input wire logic [DATA_W-1:0] sd_in,
  input wire logic [1:0]        sd_oe_n,
  input wire logic              aen,
  input wire logic              memr_n,
  input wire logic              iow_n,
  input wire logic              sbhe_n,
  input wire logic              page_port_sel_n,
  input wire logic              prog_supply_port_strobe_n,
  input wire logic              wide_bus_present_n,
  input wire logic              bus_reset,
  input wire logic              supply_ok,
  input wire logic [PAGE_W-1:0] base_sw,
  input wire logic              wide_window,
  input wire logic              eight_pair,
  input wire logic              uv_gates_decode,
  input wire logic [PAIRS-1:0]  flash_ce_lo_n,
  input wire logic [PAIRS-1:0]  flash_ce_hi_n,
  input wire logic              flash_oe_n,
  input wire logic              prog_supply_en,
  input wire logic [PAGE_W-1:0] page_number
);
  // ************
  // pin decode
  // ************
  wire logic hit  = sa[WIN_HI-1:WIN_LO] == base_sw[3:0] && (!wide_window || sa[23:20] == base_sw[7:4]);
  wire logic miss = !hit;
  wire logic uvb  = uv_gates_decode && !supply_ok;
  wire logic rdw  = hit && !aen && !memr_n && !uvb && !wide_bus_present_n && !sbhe_n && !sa[0] && !eight_pair;
  wire logic idle = flash_ce_lo_n == CS_IDLE && flash_ce_hi_n == CS_IDLE;
  wire logic [PAIRS-1:0] pair_n = ~(8'h01 << page_number[3:2]);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_aen;
    $past(aen, 3) && $past(aen, 4) |-> idle;
  endproperty
  a_aen: assert property (p_aen) else $error("chip select active with aen high");
  property p_miss;
    $past(miss, 3) && $past(miss, 4) |-> idle;
  endproperty
  a_miss: assert property (p_miss) else $error("chip select active outside window");
  property p_word;
    $past(rdw, 3) && $past(rdw, 4) |-> flash_ce_lo_n == pair_n && flash_ce_hi_n == pair_n && !flash_oe_n
      && sd_oe_n == 2'b00;
  endproperty
  a_word: assert property (p_word) else $error("word read selects wrong pair or lanes");
  property p_uv;
    $past(uvb, 3) && $past(uvb, 4) |-> idle;
  endproperty
  a_uv: assert property (p_uv) else $error("chip select active in undervoltage");
  property p_sup_clr;
    bus_reset || !supply_ok |-> !prog_supply_en;
  endproperty
  a_sup_clr: assert property (p_sup_clr) else $error("supply enable on during reset");
  property p_sup_wr;
    logic v;
    ($rose(iow_n) && !prog_supply_port_strobe_n && supply_ok && !bus_reset && clk_en, v = sd_in[SUPPLY_BIT])
      |-> ##4 prog_supply_en == v;
  endproperty
  a_sup_wr: assert property (p_sup_wr) else $error("supply enable missed a port write");
  property p_page_wr;
    logic [PAGE_W-1:0] v;
    ($rose(iow_n) && !page_port_sel_n && supply_ok && !bus_reset && clk_en, v = sd_in[PAGE_W-1:0])
      |-> ##4 page_number == v;
  endproperty
  a_page_wr: assert property (p_page_wr) else $error("page register missed a port write");
  property p_rst;
    $rose(reset_n) |-> page_number == PAGE_RESET && !prog_supply_en;
  endproperty
  a_rst: assert property (p_rst) else $error("page or supply not clear after reset");

  c_word: cover property (rdw ##4 !flash_oe_n);
  c_sup: cover property ($rose(prog_supply_en));
  c_uv: cover property (uvb && !memr_n);
endmodule : pfhd_sva

bind pfhd_top pfhd_sva u_sva (.sys_clk, .reset_n, .clk_en, .sa, .sd_in, .sd_oe_n, .aen, .memr_n, .iow_n, .sbhe_n,
  .page_port_sel_n, .prog_supply_port_strobe_n, .wide_bus_present_n, .bus_reset, .supply_ok, .base_sw,
  .wide_window, .eight_pair, .uv_gates_decode, .flash_ce_lo_n, .flash_ce_hi_n, .flash_oe_n,
  .prog_supply_en, .page_number);
`default_nettype wire

// ---- pfhd_host.sv ----
// host bus master model: memory and I/O cycles on the board's bus pins
// assumes a free-running sys_clk; every pin moves only at the falling edge
`timescale 1ns/100ps
`default_nettype none
module pfhd_host
  import pfhd_pkg::*;
(
  input  wire logic              sys_clk,
  output var  logic [ADDR_W-1:0] sa,
  output var  logic [DATA_W-1:0] sd_in,
  output var  logic              aen,
  output var  logic              memr_n,
  output var  logic              memw_n,
  output var  logic              ior_n,
  output var  logic              iow_n,
  output var  logic              sbhe_n,
  output var  logic              page_port_sel_n,
  output var  logic              base_port_sel_n,
  output var  logic              prog_supply_port_strobe_n
);
  initial begin
    {sa, sd_in} = '0;
    {aen, memr_n, memw_n, ior_n, iow_n, sbhe_n} = '1;
    {page_port_sel_n, base_port_sel_n, prog_supply_port_strobe_n} = '1;
  end

  // ************
  // cycles: strobes {memr, memw, ior, iow}, selects {page, base, supply}
  // ************
  task automatic bus_on(input logic [3:0] stb_n, input logic a_en, input logic [ADDR_W-1:0] a,
                        input logic sb_n, input logic [2:0] sel_n, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    {sa, aen, sbhe_n, sd_in} = {a, a_en, sb_n, d};
    {page_port_sel_n, base_port_sel_n, prog_supply_port_strobe_n} = sel_n;
    {memr_n, memw_n, ior_n, iow_n} = stb_n;
    repeat (5) @(negedge sys_clk);
  endtask : bus_on

  // select and data outlast the strobe by a cycle; released data shows its inverse
  task automatic bus_off;
    @(negedge sys_clk);
    {memr_n, memw_n, ior_n, iow_n} = '1;
    @(negedge sys_clk);
    {page_port_sel_n, base_port_sel_n, prog_supply_port_strobe_n} = '1;
    {aen, sbhe_n, sd_in} = {2'b11, ~sd_in};
    repeat (4) @(negedge sys_clk);
  endtask : bus_off
endmodule : pfhd_host
`default_nettype wire

// ---- pfhd_top_tb.sv ----
// self-checking bench for the paged flash decode top
// assumes the host model drives the bus pins; the bench drives straps, supply and flash data
`timescale 1ns/100ps
`default_nettype none
module pfhd_top_tb;
  import pfhd_pkg::*;
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [ADDR_W-1:0] addr;
    logic              sb_n;
    logic              nar;
    logic              eight;
    logic [PAIRS-1:0]  lo;
    logic [PAIRS-1:0]  hi;
    logic [1:0]        oe;
  } pfhd_row_t;
  localparam int SETTLE = 20;
  localparam pfhd_row_t ROWS [6] = '{
    '{8'h00, 24'h0D0000, 1'b0, 1'b0, 1'b0, 8'hFE, 8'hFE, 2'h0},
    '{8'h0C, 24'h0D0001, 1'b0, 1'b0, 1'b0, 8'hFF, 8'hF7, 2'h1},
    '{8'h04, 24'h0D0000, 1'b1, 1'b0, 1'b0, 8'hFD, 8'hFF, 2'h2},
    '{8'h08, 24'h0D0001, 1'b1, 1'b1, 1'b0, 8'hFF, 8'hFB, 2'h2},
    '{8'h1C, 24'h0D0000, 1'b0, 1'b0, 1'b1, 8'h7F, 8'h7F, 2'h0},
    '{8'h00, 24'h0E0000, 1'b0, 1'b0, 1'b0, 8'hFF, 8'hFF, 2'h3}};
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              wide_bus_present_n = 1'b0;
  logic              bus_reset = 1'b0;
  logic              supply_ok = 1'b1;
  logic [PAGE_W-1:0] base_sw = 8'h0D;
  logic              wide_window = 1'b0;
  logic              eight_pair = 1'b0;
  logic              uv_gates_decode = 1'b0;
  logic              clk_en = 1'b1;
  logic [DATA_W-1:0] fd_in = 16'hA55A;
  logic [ADDR_W-1:0] sa, flash_addr;
  logic [DATA_W-1:0] sd_in, sd_out, fd_out;
  logic [1:0]        sd_oe_n, fd_oe_n;
  logic [PAIRS-1:0]  flash_ce_lo_n, flash_ce_hi_n;
  logic [PAGE_W-1:0] page_number;
  logic              aen, memr_n, memw_n, ior_n, iow_n, sbhe_n, flash_oe_n, flash_we_n, prog_supply_en;
  logic              page_port_sel_n, base_port_sel_n, prog_supply_port_strobe_n;
  int                n_errors = 0;
  int                n_checks = 0;

  always #50 sys_clk = ~sys_clk;

  pfhd_host u_host (.sys_clk, .sa, .sd_in, .aen, .memr_n, .memw_n, .ior_n, .iow_n, .sbhe_n,
    .page_port_sel_n, .base_port_sel_n, .prog_supply_port_strobe_n);
  pfhd_top u_dut (.sys_clk, .reset_n, .clk_en, .sa, .sd_in, .sd_out, .sd_oe_n, .aen, .memr_n,
    .memw_n, .ior_n, .iow_n, .sbhe_n, .page_port_sel_n, .base_port_sel_n, .prog_supply_port_strobe_n,
    .wide_bus_present_n, .bus_reset, .supply_ok, .base_sw, .wide_window, .eight_pair, .uv_gates_decode,
    .fd_in, .fd_out, .fd_oe_n, .flash_addr, .flash_ce_lo_n, .flash_ce_hi_n, .flash_oe_n, .flash_we_n,
    .prog_supply_en, .page_number);

  // ************
  // tasks
  // ************
  task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] sel_n, input logic [PAGE_W-1:0] v);
    u_host.bus_on(4'b1110, 1'b0, ADDR_ZERO, 1'b1, sel_n, {8'h00, v});
    u_host.bus_off();
  endtask : wr
  task automatic mem_chk(input logic [ADDR_W-1:0] a, input logic sb_n, input logic [PAIRS-1:0] lo,
                         input logic [PAIRS-1:0] hi, input logic [1:0] oe);
    u_host.bus_on(4'b0111, 1'b0, a, sb_n, 3'b111, DATA_ZERO);
    chk(flash_ce_lo_n, lo);
    chk(flash_ce_hi_n, hi);
    chk(sd_oe_n, oe);
    u_host.bus_off();
  endtask : mem_chk
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ************
  // sequence
  // ************
  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(page_number, PAGE_RESET);
    chk(prog_supply_en, 1'b0);
    chk(flash_ce_lo_n, CS_IDLE);
    foreach (ROWS[i]) begin
      wide_bus_present_n = ROWS[i].nar;
      eight_pair = ROWS[i].eight;
      wr(3'b011, ROWS[i].page);
      mem_chk(ROWS[i].addr, ROWS[i].sb_n, ROWS[i].lo, ROWS[i].hi, ROWS[i].oe);
      chk(flash_addr, {ROWS[i].page, ROWS[i].addr[OFFS_W-1:0]});
    end
    wide_bus_present_n = 1'b1;
    u_host.bus_on(4'b0111, 1'b0, 24'h0D0001, 1'b1, 3'b111, DATA_ZERO);
    chk(sd_out[BYTE_W-1:0], fd_in[DATA_W-1:BYTE_W]);
    chk(flash_oe_n, 1'b0);
    u_host.bus_off();
    wide_bus_present_n = 1'b0;
    wr(3'b011, 8'hA7);
    u_host.bus_on(4'b1101, 1'b0, ADDR_ZERO, 1'b1, 3'b011, DATA_ZERO);
    chk(sd_out, 16'h00A7);
    chk(sd_oe_n, 2'b10);
    u_host.bus_off();
    u_host.bus_on(4'b0111, 1'b1, 24'h0D0000, 1'b0, 3'b111, DATA_ZERO);
    chk(flash_ce_lo_n, CS_IDLE);
    u_host.bus_off();
    u_host.bus_on(4'b1011, 1'b0, 24'h0D0000, 1'b0, 3'b111, 16'h3C69);
    chk(flash_we_n, 1'b0);
    chk(fd_out, 16'h3C69);
    chk(fd_oe_n, 2'b00);
    u_host.bus_off();
    wr(3'b110, 8'h01);
    chk(prog_supply_en, 1'b1);
    repeat (SETTLE) @(negedge sys_clk);
    wr(3'b110, 8'h00);
    chk(prog_supply_en, 1'b0);
    wr(3'b110, 8'h01);
    @(negedge sys_clk);
    bus_reset = 1'b1;
    #1 chk(prog_supply_en, 1'b0);
    @(negedge sys_clk);
    bus_reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr(3'b110, 8'h01);
    supply_ok = 1'b0;
    #1 chk(prog_supply_en, 1'b0);
    repeat (4) @(negedge sys_clk);
    chk(page_number, PAGE_RESET);
    uv_gates_decode = 1'b1;
    mem_chk(24'h0D0000, 1'b0, CS_IDLE, CS_IDLE, LANES_OFF);
    supply_ok = 1'b1;
    repeat (4) @(negedge sys_clk);
    mem_chk(24'h0D0000, 1'b0, 8'hFE, 8'hFE, 2'b00);
    wide_window = 1'b1;
    base_sw = 8'h1D;
    repeat (4) @(negedge sys_clk);
    mem_chk(24'h1D0000, 1'b0, 8'hFE, 8'hFE, 2'b00);
    mem_chk(24'h0D0000, 1'b0, CS_IDLE, CS_IDLE, LANES_OFF);
    u_host.bus_on(4'b1101, 1'b0, ADDR_ZERO, 1'b1, 3'b101, DATA_ZERO);
    chk(sd_out, 16'h001D);
    u_host.bus_off();
    // a frozen block must ignore a full page write
    clk_en = 1'b0;
    wr(3'b011, 8'h5A);
    chk(page_number, PAGE_RESET);
    clk_en = 1'b1;
    test_done();
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
endmodule : pfhd_top_tb
`default_nettype wire
